// >>> tcis_defines.vh
// constants for the timer capture input stage: register offsets,
// field positions, reset values and edge-select codes
// assumes inclusion by bare name from the design files
`ifndef TCIS_DEFINES_VH
`define TCIS_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define TCIS_OFS_CTRL        8'h00
`define TCIS_OFS_PRESCALER   8'h04
`define TCIS_OFS_COUNT       8'h08
`define TCIS_OFS_CAP_A       8'h0C
`define TCIS_OFS_CAP_B       8'h10
`define TCIS_OFS_IRQ_STATUS  8'h14
`define TCIS_OFS_IRQ_MASK    8'h18

// ****************************************
// control register fields
// ****************************************
`define TCIS_CTRL_RUN        0
`define TCIS_CTRL_SRC_PIN_A  1
`define TCIS_CTRL_CAPMODE_A  2
`define TCIS_CTRL_CAPMODE_B  3
`define TCIS_CTRL_W          4
`define TCIS_CTRL_RST        4'h0

// ****************************************
// prescaler mode register fields
// ****************************************
`define TCIS_PRM_DIV_LO      0
`define TCIS_PRM_DIV_HI      1
`define TCIS_PRM_EDGE_A_LO   4
`define TCIS_PRM_EDGE_A_HI   5
`define TCIS_PRM_EDGE_B_LO   6
`define TCIS_PRM_EDGE_B_HI   7
`define TCIS_PRM_W           8
`define TCIS_PRM_RST         8'h00

// ****************************************
// edge select codes
// ****************************************
`define TCIS_EDGE_FALL       2'h0
`define TCIS_EDGE_RISE       2'h1
`define TCIS_EDGE_NONE       2'h2
`define TCIS_EDGE_BOTH       2'h3

// ****************************************
// interrupt status bits
// ****************************************
`define TCIS_IRQ_CAP_A       0
`define TCIS_IRQ_CAP_B       1
`define TCIS_IRQ_W           2

`endif

// >>> tcis_prescaler.v
// count clock generator: divides core_clk into a square count clock
// assumes a synchronous active-high reset on the same clock
`timescale 1ns/1ps
`default_nettype none

module tcis_prescaler
#(
   parameter DIV_W = 8                     // width of the half-period counter
)
(
   input  wire             core_clk,       // system clock
   input  wire             rst,            // synchronous reset
   input  wire [1:0]       div_sel,        // half period is 1 << div_sel cycles
   output reg              rise_pulse_q,   // count clock rising edge
   output reg              fall_pulse_q    // count clock falling edge
);

   // ****************************************
   // half-period counter
   // ****************************************
   reg  [DIV_W-1:0] div_q;                 // cycles into the half period
   reg              level_q;               // count clock level
   wire [DIV_W-1:0] half_last;             // last cycle of the half period

   assign half_last = ({{(DIV_W-1){1'b0}}, 1'b1} << div_sel) - {{(DIV_W-1){1'b0}}, 1'b1};

   // toggle the count clock; edges leave as one-cycle pulses
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         div_q        <= {DIV_W{1'b0}};
         level_q      <= 1'b0;
         rise_pulse_q <= 1'b0;
         fall_pulse_q <= 1'b0;
      end
      else if (div_q >= half_last)
      begin
         // a lowered select mid-period ends the half period at once
         div_q        <= {DIV_W{1'b0}};
         level_q      <= ~level_q;
         rise_pulse_q <= ~level_q;
         fall_pulse_q <= level_q;
      end
      else
      begin
         div_q        <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
         rise_pulse_q <= 1'b0;
         fall_pulse_q <= 1'b0;
      end
   end

endmodule // tcis_prescaler

`default_nettype wire

// >>> tcis_pin_filter.v
// trigger pin conditioner: two-flop synchroniser, two-sample noise
// filter and edge detector with an arming memory across stops
// assumes the sample strobe and run level come from core_clk logic
`timescale 1ns/1ps
`default_nettype none

`include "tcis_defines.vh"

module tcis_pin_filter
(
   input  wire       core_clk,      // system clock
   input  wire       rst,           // synchronous reset
   input  wire       pin,           // raw trigger pin
   input  wire       sample_en,     // filter sampling strobe
   input  wire       run,           // counter running
   input  wire [1:0] edge_sel,      // valid edge code
   output reg        valid_edge_q   // one-cycle valid edge
);

   // ****************************************
   // synchroniser and filter
   // ****************************************
   reg meta_q;                      // first synchroniser stage
   reg sync_q;                      // second synchroniser stage
   reg samp_q;                      // previous filter sample
   reg level_q;                     // filtered level
   reg prev_q;                      // level seen by the edge detector
   reg started_q;                   // counter has run since reset
   reg hit;                         // edge matches selection

   // level only moves when two successive samples agree
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         meta_q  <= 1'b0;
         sync_q  <= 1'b0;
         samp_q  <= 1'b0;
         level_q <= 1'b0;
      end
      else
      begin
         meta_q <= pin;
         sync_q <= meta_q;
         if (sample_en)
         begin
            samp_q <= sync_q;
            if (samp_q == sync_q)
               level_q <= sync_q;
         end
      end
   end

   // edge match against the selected code
   always @*
   begin
      case (edge_sel)
         `TCIS_EDGE_FALL: hit = prev_q & ~level_q;
         `TCIS_EDGE_RISE: hit = ~prev_q & level_q;
         `TCIS_EDGE_BOTH: hit = prev_q ^ level_q;
         default:         hit = 1'b0;
      endcase
   end

   // ****************************************
   // edge detector
   // ****************************************
   // prev stays low until first run so a high pin shows as a rise;
   // after that it tracks even while stopped, so a restart is quiet
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         prev_q       <= 1'b0;
         started_q    <= 1'b0;
         valid_edge_q <= 1'b0;
      end
      else
      begin
         if (run)
            started_q <= 1'b1;
         if (run || started_q)
            prev_q <= level_q;
         valid_edge_q <= run & hit;
      end
   end

endmodule // tcis_pin_filter

`default_nettype wire

// >>> tcis_capture_stage.v
// top of the timer capture input stage with its APB register file
// assumes an APB master on core_clk and raw asynchronous trigger pins
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "tcis_defines.vh"

module tcis_capture_stage
#(
   parameter CNT_W = 16                    // counter and capture width
)
(
   input  wire        core_clk,            // system clock, 20 MHz
   input  wire        rst,                 // synchronous reset, active high
   input  wire        psel,                // apb select
   input  wire        penable,             // apb access phase
   input  wire        pwrite,              // apb direction
   input  wire [7:0]  paddr,               // apb byte address
   input  wire [31:0] pwdata,              // apb write data
   output reg  [31:0] prdata,              // apb read data
   output reg         pready,              // apb ready
   output reg         pslverr,             // apb error on unmapped address
   input  wire        trigger_pin_a,       // raw trigger pin a
   input  wire        trigger_pin_b,       // raw trigger pin b
   output reg         irq                  // level interrupt
);

   // ****************************************
   // register state
   // ****************************************
   reg  [`TCIS_CTRL_W-1:0] ctrl_q;         // run, source, capture modes
   reg  [`TCIS_PRM_W-1:0]  prescaler_mode_reg_q; // divider and edges
   reg  [CNT_W-1:0]        main_counter_q; // running count
   reg  [CNT_W-1:0]        capture_reg_a_q; // capture a
   reg  [CNT_W-1:0]        capture_reg_b_q; // capture b
   reg  [`TCIS_IRQ_W-1:0]  irq_status_q;   // sticky events
   reg  [`TCIS_IRQ_W-1:0]  irq_status_d;   // next sticky events
   reg  [`TCIS_IRQ_W-1:0]  irq_mask_q;     // interrupt enables
   reg                     pend_a_q;       // trigger a waiting for fall
   reg                     pend_b_q;       // trigger b waiting for fall
   reg                     irq_arm_a_q;    // capture a done, awaiting rise
   reg                     irq_arm_b_q;    // capture b done, awaiting rise

   // ****************************************
   // decoded controls
   // ****************************************
   wire       run        = ctrl_q[`TCIS_CTRL_RUN];
   wire       src_pin_a  = ctrl_q[`TCIS_CTRL_SRC_PIN_A];
   wire       capmode_a  = ctrl_q[`TCIS_CTRL_CAPMODE_A];
   wire       capmode_b  = ctrl_q[`TCIS_CTRL_CAPMODE_B];
   wire [1:0] div_sel    = prescaler_mode_reg_q[`TCIS_PRM_DIV_HI:`TCIS_PRM_DIV_LO];
   wire [1:0] edge_select_a = prescaler_mode_reg_q[`TCIS_PRM_EDGE_A_HI:`TCIS_PRM_EDGE_A_LO];
   wire [1:0] edge_select_b = prescaler_mode_reg_q[`TCIS_PRM_EDGE_B_HI:`TCIS_PRM_EDGE_B_LO];

   wire       cclk_rise;                   // count clock rising pulse
   wire       cclk_fall;                   // count clock falling pulse
   wire       edge_a;                      // filtered valid edge, pin a
   wire       edge_b;                      // filtered valid edge, pin b
   wire       sample_a;                    // filter strobe, pin a

   // ****************************************
   // bus decode
   // ****************************************
   wire       acc_done = psel & penable & pready;   // completing edge
   wire       wr_done  = acc_done & pwrite;         // write takes effect
   wire [`TCIS_IRQ_W-1:0] w1c = (wr_done && paddr == `TCIS_OFS_IRQ_STATUS) ?
                                pwdata[`TCIS_IRQ_W-1:0] : {`TCIS_IRQ_W{1'b0}};

   // mapped-address check for the error flag; the read mux decodes on its own
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a == `TCIS_OFS_CTRL) || (a == `TCIS_OFS_PRESCALER) ||
                     (a == `TCIS_OFS_COUNT) || (a == `TCIS_OFS_CAP_A) ||
                     (a == `TCIS_OFS_CAP_B) || (a == `TCIS_OFS_IRQ_STATUS) ||
                     (a == `TCIS_OFS_IRQ_MASK);
      end
   endfunction

   // ****************************************
   // count clock and pin conditioning
   // ****************************************
   tcis_prescaler #(.DIV_W(8)) u_presc
   (
      .core_clk     (core_clk),
      .rst          (rst),
      .div_sel      (div_sel),
      .rise_pulse_q (cclk_rise),
      .fall_pulse_q (cclk_fall)
   );

   // counting from the pin needs the fast sampler, capture the slow one
   assign sample_a = src_pin_a ? 1'b1 : cclk_rise;

   tcis_pin_filter u_filt_a
   (
      .core_clk     (core_clk),
      .rst          (rst),
      .pin          (trigger_pin_a),
      .sample_en    (sample_a),
      .run          (run),
      .edge_sel     (edge_select_a),
      .valid_edge_q (edge_a)
   );

   tcis_pin_filter u_filt_b
   (
      .core_clk     (core_clk),
      .rst          (rst),
      .pin          (trigger_pin_b),
      .sample_en    (cclk_rise),
      .run          (run),
      .edge_sel     (edge_select_b),
      .valid_edge_q (edge_b)
   );

   // ****************************************
   // control registers
   // ****************************************
   // software writes land only on the completing access edge
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         ctrl_q               <= `TCIS_CTRL_RST;
         prescaler_mode_reg_q <= `TCIS_PRM_RST;
         irq_mask_q           <= {`TCIS_IRQ_W{1'b0}};
      end
      else if (wr_done)
      begin
         case (paddr)
            `TCIS_OFS_CTRL:      ctrl_q <= pwdata[`TCIS_CTRL_W-1:0];
            `TCIS_OFS_PRESCALER: prescaler_mode_reg_q <= pwdata[`TCIS_PRM_W-1:0];
            `TCIS_OFS_IRQ_MASK:  irq_mask_q <= pwdata[`TCIS_IRQ_W-1:0];
            default:             ctrl_q <= ctrl_q;  // read-only, unmapped, or irq status (cleared through w1c)
         endcase
      end
   end

   // ****************************************
   // main counter
   // ****************************************
   // counts count clock rises, or pin a edges when that pin is the source
   always @(posedge core_clk)
   begin
      if (rst)
         main_counter_q <= {CNT_W{1'b0}};
      else if (run && (src_pin_a ? edge_a : cclk_rise))
         main_counter_q <= main_counter_q + {{(CNT_W-1){1'b0}}, 1'b1};
   end

   // ****************************************
   // capture path
   // ****************************************
   // edges wait in a pending flag for the next count clock fall; a
   // pulse shorter than two count clocks may be missed by the filter
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         pend_a_q        <= 1'b0;
         pend_b_q        <= 1'b0;
         capture_reg_a_q <= {CNT_W{1'b0}};
         capture_reg_b_q <= {CNT_W{1'b0}};
         irq_arm_a_q     <= 1'b0;
         irq_arm_b_q     <= 1'b0;
      end
      else if (!run)
      begin
         pend_a_q    <= 1'b0;
         pend_b_q    <= 1'b0;
         irq_arm_a_q <= 1'b0;
         irq_arm_b_q <= 1'b0;
      end
      else
      begin
         // pin a never captures while it clocks the counter
         if (edge_a && capmode_a && !src_pin_a)
            pend_a_q <= 1'b1;
         else if (cclk_fall)
            pend_a_q <= 1'b0;
         if (edge_b && capmode_b)
            pend_b_q <= 1'b1;
         else if (cclk_fall)
            pend_b_q <= 1'b0;
         // latch on the fall; a coincident read never blocks it
         if (cclk_fall && pend_a_q)
            capture_reg_a_q <= main_counter_q;
         if (cclk_fall && pend_b_q)
            capture_reg_b_q <= main_counter_q;
         // arm on capture, fire on the next rise
         if (cclk_fall && pend_a_q)
            irq_arm_a_q <= 1'b1;
         else if (cclk_rise)
            irq_arm_a_q <= 1'b0;
         if (cclk_fall && pend_b_q)
            irq_arm_b_q <= 1'b1;
         else if (cclk_rise)
            irq_arm_b_q <= 1'b0;
      end
   end

   // ****************************************
   // interrupt status
   // ****************************************
   // a set in the same cycle as its clear wins
   always @*
   begin
      irq_status_d = irq_status_q & ~w1c;
      if (cclk_rise && irq_arm_a_q)
         irq_status_d[`TCIS_IRQ_CAP_A] = 1'b1;
      if (cclk_rise && irq_arm_b_q)
         irq_status_d[`TCIS_IRQ_CAP_B] = 1'b1;
   end

   // sticky bits and the gated interrupt level
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         irq_status_q <= {`TCIS_IRQ_W{1'b0}};
         irq          <= 1'b0;
      end
      else
      begin
         irq_status_q <= irq_status_d;
         irq          <= |(irq_status_d & irq_mask_q);
      end
   end

   // ****************************************
   // apb response
   // ****************************************
   // one wait state: ready rises in the second access cycle, so read
   // data is registered against a stable address
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~is_mapped(paddr);
         prdata  <= 32'h00000000;
         if (psel && penable && !pready && !pwrite)
         begin
            case (paddr)
               `TCIS_OFS_CTRL:       prdata[`TCIS_CTRL_W-1:0] <= ctrl_q;
               `TCIS_OFS_PRESCALER:  prdata[`TCIS_PRM_W-1:0] <= prescaler_mode_reg_q;
               `TCIS_OFS_COUNT:      prdata[CNT_W-1:0] <= main_counter_q;
               `TCIS_OFS_CAP_A:      prdata[CNT_W-1:0] <= capture_reg_a_q;
               `TCIS_OFS_CAP_B:      prdata[CNT_W-1:0] <= capture_reg_b_q;
               `TCIS_OFS_IRQ_STATUS: prdata[`TCIS_IRQ_W-1:0] <= irq_status_q;
               `TCIS_OFS_IRQ_MASK:   prdata[`TCIS_IRQ_W-1:0] <= irq_mask_q;
               default:              prdata <= 32'h00000000; // unmapped
            endcase
         end
      end
   end

endmodule // tcis_capture_stage

`default_nettype wire

// >>> tcis_monitor.sv
// checker for the capture stage: apb timing and irq behaviour
// assumes binding onto tcis_capture_stage, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tcis_monitor
(
   input wire logic        core_clk, // system clock
   input wire logic        rst,      // sync reset
   input wire logic        psel,     // apb select
   input wire logic        penable,  // apb access
   input wire logic        pwrite,   // apb direction
   input wire logic [31:0] prdata,   // read data
   input wire logic        pready,   // ready
   input wire logic        pslverr,  // error
   input wire logic        irq       // interrupt
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ******
   // apb answer
   // ******
   a_one_wait: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
      else $error("pready late after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   a_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("prdata not zero on error");
   // ******
   // interrupt and reset
   // ******
   // a sticky irq only drops after a register write
   a_irq_fall_write: assert property ($fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2))
      else $error("irq fell without a write");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !pready && !irq && !pslverr)
      else $error("outputs active after reset");
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
   c_wr: cover property (pready && pwrite);
   c_rd: cover property (pready && !pwrite);
endmodule // tcis_monitor
bind tcis_capture_stage tcis_monitor mon_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// >>> tcis_pin_src.sv
// trigger pin source: steps or pulses one pin on request
// assumes requests come from the bench on core_clk
`timescale 1ns/1ps
`default_nettype none
module tcis_pin_src
#(
   parameter logic INIT = 1'b0          // level after reset
)
(
   input  wire logic       core_clk, // system clock
   input  wire logic       rst,      // sync reset
   input  wire logic       go,       // toggle request
   input  wire logic [7:0] len,      // pulse length, 0 for a step
   output var  logic       pin       // driven pin
);
   logic [7:0] cnt_q;                   // cycles left in a pulse
   // a pulse reverts after len cycles; the bench picks len so that
   // the pulse spans at least two count clocks, or less to make a glitch
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pin <= INIT;
         cnt_q <= 8'h00;
      end
      else if (go)
      begin
         pin <= ~pin;
         cnt_q <= len;
      end
      else if (cnt_q != 8'h00)
      begin
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h01)
            pin <= ~pin;
      end
   end
endmodule // tcis_pin_src
`default_nettype wire

// >>> timer_capture_input_stage_tb_top.sv
// self-checking bench for the capture stage
// assumes the design, the pin source and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tcis_defines.vh"
module timer_capture_input_stage_tb_top;
   logic        core_clk, rst, psel, penable, pwrite;  // clock, reset, apb
   logic [7:0]  paddr, glen;                           // address, pulse length
   logic [31:0] pwdata, prdata, rd, c0, c1, cb;        // data and snapshots
   logic        pready, pslverr, irq, pin_a, pin_b;    // design outputs, pins
   logic        go_a, go_b, e, lvl_a;                  // requests, error, pin a level
   logic [1:0]  code;                                  // edge code under test
   int          miscompares, n_tests;                  // tallies
   tcis_capture_stage dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trigger_pin_a(pin_a), .trigger_pin_b(pin_b), .irq(irq));
   tcis_pin_src #(.INIT(1'b1)) src_a_u (.core_clk(core_clk), .rst(rst), .go(go_a), .len(glen), .pin(pin_a));
   tcis_pin_src #(.INIT(1'b0)) src_b_u (.core_clk(core_clk), .rst(rst), .go(go_b), .len(glen), .pin(pin_b));
   // ******
   // helpers
   // ******
   task automatic close_out;
      if (miscompares == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   // one apb transfer; entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      // ready, data and error are taken at the rising edge that completes
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         miscompares++;
         close_out();
      end
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next setup never reassigns psel in this step
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdv(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // step (len 0) or pulse a pin, then let the stage settle
   task automatic kick(input logic b, input logic [7:0] len);
      glen <= len;
      if (b)
         go_b <= 1'b1;
      else
         go_a <= 1'b1;
      @(posedge core_clk);
      go_a <= 1'b0;
      go_b <= 1'b0;
      repeat (60) @(posedge core_clk);
   endtask
   // whether an edge code accepts a rise or a fall
   function automatic logic hit(input logic [1:0] c, input logic up);
      return c == `TCIS_EDGE_BOTH || (up ? c == `TCIS_EDGE_RISE : c == `TCIS_EDGE_FALL);
   endfunction
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // ******
   // main sequence
   // ******
   initial
   begin
      {rst, psel, penable, pwrite, go_a, go_b, lvl_a} = 7'h41;
      {paddr, glen, pwdata} = 48'h0;
      miscompares = 0;
      n_tests = 0;
      rd = $urandom(32'hEE7C4175);
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      // all registers clear after reset, unmapped slot refused
      for (int i = 0; i < 7; i++)
      begin
         rdv(8'(i * 4));
         chk("reset_value", 32'h0, rd);
      end
      rdv(8'h1C);
      chk("unmapped_err", 32'h1, 32'(e));
      // pin a high since reset, rise code: edge at first run
      wr(`TCIS_OFS_IRQ_MASK, 32'h3);
      wr(`TCIS_OFS_PRESCALER, 32'hD0);
      wr(`TCIS_OFS_CTRL, 32'h0D);
      repeat (40) @(posedge core_clk);
      rdv(`TCIS_OFS_IRQ_STATUS);
      chk("first_run_rise", 32'h1, rd);
      chk("irq_raised", 32'h1, 32'(irq));
      wr(`TCIS_OFS_IRQ_STATUS, 32'h1);
      repeat (3) @(posedge core_clk);
      chk("irq_cleared", 32'h0, 32'(irq));
      // stop and restart with pin a still high
      wr(`TCIS_OFS_CTRL, 32'h0C);
      wr(`TCIS_OFS_CTRL, 32'h0D);
      repeat (40) @(posedge core_clk);
      rdv(`TCIS_OFS_IRQ_STATUS);
      chk("rerun_no_rise", 32'h0, rd);
      // one-cycle glitch on pin b is rejected
      kick(1'b1, 8'd1);
      rdv(`TCIS_OFS_IRQ_STATUS);
      chk("glitch_reject", 32'h0, rd);
      // real pulse on pin b, irq of b masked out
      wr(`TCIS_OFS_IRQ_MASK, 32'h1);
      rdv(`TCIS_OFS_COUNT);
      c0 = rd;
      kick(1'b1, 8'd8);
      rdv(`TCIS_OFS_CAP_B);
      cb = rd;
      rdv(`TCIS_OFS_COUNT);
      c1 = rd;
      rdv(`TCIS_OFS_IRQ_STATUS);
      chk("pulse_capture", 32'h2, rd);
      chk("irq_masked", 32'h0, 32'(irq));
      chk("cap_window", 32'h1, 32'(cb >= c0 && cb <= c1));
      chk("count_runs", 32'h1, 32'(c1 > c0));
      // compare mode on b takes no capture
      wr(`TCIS_OFS_IRQ_STATUS, 32'h3);
      wr(`TCIS_OFS_CTRL, 32'h05);
      kick(1'b1, 8'd8);
      rdv(`TCIS_OFS_IRQ_STATUS);
      chk("compare_no_flag", 32'h0, rd);
      rdv(`TCIS_OFS_CAP_B);
      chk("compare_no_cap", cb, rd);
      // stopped counter ignores both pins
      wr(`TCIS_OFS_CTRL, 32'h0C);
      kick(1'b1, 8'd8);
      kick(1'b0, 8'd0);
      lvl_a = ~lvl_a;
      rdv(`TCIS_OFS_IRQ_STATUS);
      chk("stopped_ignore", 32'h0, rd);
      // pin a as count source: counts one rise, never captures;
      // slow count clock and a short pulse, so only the fast sampler sees it
      wr(`TCIS_OFS_CTRL, 32'h0F);
      wr(`TCIS_OFS_PRESCALER, 32'hD3);
      rdv(`TCIS_OFS_COUNT);
      c0 = rd;
      kick(1'b0, 8'd4);
      rdv(`TCIS_OFS_COUNT);
      chk("pin_a_counts", c0 + 32'h1, rd);
      rdv(`TCIS_OFS_IRQ_STATUS);
      chk("pin_a_no_cap", 32'h0, rd);
      // every edge code of pin a, both directions, random divider
      for (int k = 0; k < 8; k++)
      begin
         code = 2'(k >> 1);
         wr(`TCIS_OFS_CTRL, 32'h0C);
         wr(`TCIS_OFS_PRESCALER, {24'h0, 2'b10, code, 2'b00, 2'($urandom)});
         wr(`TCIS_OFS_CTRL, 32'h0D);
         wr(`TCIS_OFS_IRQ_STATUS, 32'h3);
         kick(1'b0, 8'd0);
         lvl_a = ~lvl_a;
         rdv(`TCIS_OFS_IRQ_STATUS);
         chk("edge_code", 32'(hit(code, lvl_a)), rd);
      end
      close_out();
   end
endmodule // timer_capture_input_stage_tb_top
`default_nettype wire
